// ==== afc_pkg.sv ====
package afc_pkg;

  // ---------------------------------------------------------------
  // widths and depths
  // ---------------------------------------------------------------
  localparam int CR_W = 10;
  localparam int DATA_W = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int CHAN_W = 2;

  // ---------------------------------------------------------------
  // register select field on the data bus during a write
  // ---------------------------------------------------------------
  localparam int REG_SEL_HI = 11;
  localparam int REG_SEL_LO = 10;
  localparam logic [1:0] REG_SEL_CR0 = 2'h0;
  localparam logic [1:0] REG_SEL_CR1 = 2'h1;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [CR_W-1:0] CR0_RESET = 10'h000;
  localparam logic [CR_W-1:0] CR1_RESET = 10'h030;
  localparam logic [2:0] STARTUP_CYCLES = 3'h5;
  localparam logic [DATA_W-1:0] MID_CODE = 12'h800;
  localparam logic [1:0] RB_DONE = 2'h2;

  // ---------------------------------------------------------------
  // channel configuration field positions in control register 0
  // ---------------------------------------------------------------
  localparam int CR0_SCAN = 7;
  localparam int CR0_CFG_HI = 6;
  localparam int CR0_CFG_LO = 3;

  // ---------------------------------------------------------------
  // control register 1 layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic config_readback_en;
    logic offset_cal;
    logic number_format_sel;
    logic rw_combined;
    logic dav_polarity;
    logic dav_pulse;
    logic fill_threshold_msb;
    logic fill_threshold_lsb;
    logic fifo_clear_cmd;
    logic soft_reset;
  } afc_cr1_t;

  typedef struct packed {
    logic [1:0] reg_sel;
    logic [CR_W-1:0] value;
  } afc_bus_word_t;

  // number of channels from the scan and config bits of register 0
  function automatic logic [2:0] afc_chan_count(input logic [CR_W-1:0] cr0);
    logic [3:0] cfg;
    cfg = cr0[CR0_CFG_HI:CR0_CFG_LO];
    afc_chan_count = 3'h1;
    if (cr0[CR0_SCAN]) begin
      case (cfg)
        4'h1, 4'h5, 4'h9: afc_chan_count = 3'h2;
        4'h2, 4'h6: afc_chan_count = 3'h3;
        4'h3: afc_chan_count = 3'h4;
        default: afc_chan_count = 3'h1;
      endcase
    end
  endfunction

  // trigger level in samples; reserved code falls back to the smallest
  function automatic logic [CNT_W-1:0] afc_trig_level(input logic [2:0] nch,
                                                      input logic [1:0] code);
    afc_trig_level = 5'h01;
    case (nch)
      3'h2: begin
        case (code)
          2'h0: afc_trig_level = 5'h02;
          2'h1: afc_trig_level = 5'h04;
          2'h2: afc_trig_level = 5'h08;
          default: afc_trig_level = 5'h0C;
        endcase
      end
      3'h3: begin
        case (code)
          2'h0: afc_trig_level = 5'h03;
          2'h1: afc_trig_level = 5'h06;
          2'h2: afc_trig_level = 5'h09;
          default: afc_trig_level = 5'h0C;
        endcase
      end
      3'h4: begin
        case (code)
          2'h1: afc_trig_level = 5'h08;
          2'h2: afc_trig_level = 5'h0C;
          default: afc_trig_level = 5'h04;
        endcase
      end
      default: begin
        case (code)
          2'h0: afc_trig_level = 5'h01;
          2'h1: afc_trig_level = 5'h04;
          2'h2: afc_trig_level = 5'h08;
          default: afc_trig_level = 5'h0E;
        endcase
      end
    endcase
  endfunction

endpackage

// ==== afc_fifo.sv ====
`timescale 1ns/100ps
module afc_fifo import afc_pkg::*; #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != FULL_COUNT);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_idx];
  assign o_count = count;
  assign push = i_in_valid & o_in_ready;
  assign pop = i_out_ready & o_out_valid;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_idx] <= i_in_data;
    end
  end

  // ---------------------------------------------------------------
  // pointers and fill
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // afc_fifo

// ==== afc_ctrl.sv ====
`timescale 1ns/100ps
module afc_ctrl import afc_pkg::*; (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SELECT_LOW_N,
  input wire logic I_SELECT_HIGH,
  input wire logic I_RD_N,
  input wire logic I_WR_N,
  input wire logic [DATA_W-1:0] I_DATA,
  output logic [DATA_W-1:0] O_DATA,
  output logic O_DATA_OE_N,
  input wire logic I_CONV_VALID,
  input wire logic [DATA_W-1:0] I_CONV_DATA,
  output logic O_CONV_READY,
  output logic [CHAN_W-1:0] O_CHAN_IDX,
  output logic O_ZERO_INPUT,
  output logic O_SAMPLES_READY
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic sel;
  logic rd_int;
  logic wr_int;
  logic rd_int_q;
  logic wr_int_q;
  logic rd_start;
  logic wr_start;
  afc_bus_word_t bus_word;
  afc_cr1_t wdata;
  logic wr_cr0;
  logic wr_cr1;
  logic soft_rst;
  logic srst;
  logic fifo_clr;
  logic [CR_W-1:0] cr0;
  afc_cr1_t cr1;
  afc_cr1_t cr1_read;
  logic [2:0] startup;
  logic cal_pending;
  logic [DATA_W-1:0] corr;
  logic [DATA_W-1:0] corrected;
  logic conv_take;
  logic [CHAN_W-1:0] chan_idx;
  logic [CHAN_W-1:0] next_chan_idx;
  logic [2:0] nch;
  logic overrun;
  logic [1:0] rb_cnt;
  logic rb_active;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [DATA_W-1:0] fifo_out_data;
  logic [CNT_W-1:0] fill;
  logic [CNT_W-1:0] tl;
  logic armed;
  logic [CNT_W-1:0] reads_left;
  logic dav_active;
  logic trig_hit;
  logic next_dav_active;
  localparam afc_cr1_t CR1_INIT = afc_cr1_t'(CR1_RESET);

  // ---------------------------------------------------------------
  // bus strobe decode
  // ---------------------------------------------------------------
  always_comb begin
    sel = ~I_SELECT_LOW_N & I_SELECT_HIGH;
    if (cr1.rw_combined) begin
      rd_int = sel & I_WR_N;
      wr_int = sel & ~I_WR_N;
    end else begin
      rd_int = sel & ~I_RD_N & I_WR_N;
      wr_int = sel & ~I_WR_N & I_RD_N;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      rd_int_q <= 1'b0;
      wr_int_q <= 1'b0;
    end else begin
      rd_int_q <= rd_int;
      wr_int_q <= wr_int;
    end
  end

  assign rd_start = rd_int & ~rd_int_q;
  assign wr_start = wr_int & ~wr_int_q;
  assign bus_word = afc_bus_word_t'(I_DATA);
  assign wdata = afc_cr1_t'(bus_word.value);
  assign wr_cr0 = wr_start & (bus_word.reg_sel == REG_SEL_CR0);
  assign wr_cr1 = wr_start & (bus_word.reg_sel == REG_SEL_CR1);
  assign soft_rst = wr_cr1 & wdata.soft_reset;
  assign srst = I_SYS_RST | soft_rst;
  assign fifo_clr = wr_cr1 & wdata.fifo_clear_cmd & ~wdata.soft_reset;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      cr0 <= CR0_RESET;
    end else if (wr_cr0) begin
      cr0 <= bus_word.value;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      cr1 <= afc_cr1_t'(CR1_RESET);
    end else if (wr_cr1) begin
      cr1 <= wdata;
      cr1.soft_reset <= 1'b0;
      cr1.fifo_clear_cmd <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // start-up delay after reset
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      startup <= STARTUP_CYCLES;
    end else if (startup != '0) begin
      startup <= startup - 1'b1;
    end
  end

  assign conv_take = I_CONV_VALID & (startup == '0);

  // ---------------------------------------------------------------
  // offset calibration
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      cal_pending <= 1'b0;
      corr <= '0;
    end else begin
      if (conv_take && cal_pending) begin
        corr <= I_CONV_DATA - MID_CODE;
        cal_pending <= 1'b0;
      end
      if (wr_cr1 && wdata.offset_cal) begin
        cal_pending <= 1'b1;
      end
    end
  end

  assign corrected = I_CONV_DATA - corr;

  // ---------------------------------------------------------------
  // channel sequencing
  // ---------------------------------------------------------------
  assign nch = afc_chan_count(cr0);

  always_comb begin
    next_chan_idx = chan_idx;
    if (conv_take && !cal_pending) begin
      if (3'(chan_idx) + 3'h1 >= nch) begin
        next_chan_idx = '0;
      end else begin
        next_chan_idx = chan_idx + 1'b1;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (srst || fifo_clr || wr_cr0) begin
      chan_idx <= '0;
    end else begin
      chan_idx <= next_chan_idx;
    end
  end

  // ---------------------------------------------------------------
  // sample fifo
  // ---------------------------------------------------------------
  assign fifo_in_valid = conv_take & ~cal_pending;
  assign rb_active = cr1.config_readback_en & (rb_cnt != RB_DONE);
  assign fifo_pop = rd_start & ~rb_active & fifo_out_valid;

  afc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst(srst),
    .i_clear(fifo_clr),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(corrected),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data),
    .o_count(fill)
  );

  // ---------------------------------------------------------------
  // overrun flag
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      overrun <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (rd_start && rb_active && rb_cnt != '0) begin
      overrun <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // readback sequence
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      rb_cnt <= '0;
    end else if (wr_cr1 && wdata.config_readback_en) begin
      rb_cnt <= '0;
    end else if (rd_start && rb_active) begin
      rb_cnt <= rb_cnt + 1'b1;
    end
  end

  always_comb begin
    cr1_read = cr1;
    cr1_read.soft_reset = 1'b0;
    cr1_read.fifo_clear_cmd = overrun;
  end

  // ---------------------------------------------------------------
  // data output
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_DATA <= '0;
    end else if (rd_start) begin
      if (rb_active && rb_cnt == '0) begin
        O_DATA <= {REG_SEL_CR0, cr0};
      end else if (rb_active) begin
        O_DATA <= {REG_SEL_CR1, CR_W'(cr1_read)};
      end else if (cr1.number_format_sel) begin
        O_DATA <= fifo_out_data;
      end else begin
        O_DATA <= {~fifo_out_data[DATA_W-1], fifo_out_data[DATA_W-2:0]};
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      O_DATA_OE_N <= 1'b1;
    end else begin
      O_DATA_OE_N <= ~rd_int;
    end
  end

  // ---------------------------------------------------------------
  // samples-ready trigger
  // ---------------------------------------------------------------
  assign tl = afc_trig_level(nch, {cr1.fill_threshold_msb, cr1.fill_threshold_lsb});
  assign trig_hit = armed & (fill >= tl);

  always_ff @(posedge I_SYS_CLK) begin
    if (srst || fifo_clr) begin
      armed <= 1'b1;
      reads_left <= '0;
    end else if (trig_hit) begin
      armed <= 1'b0;
      reads_left <= tl;
    end else if (fifo_pop && reads_left != '0) begin
      reads_left <= reads_left - 1'b1;
      if (reads_left == 5'h01) begin
        armed <= 1'b1;
      end
    end
  end

  always_comb begin
    next_dav_active = dav_active;
    if (trig_hit) begin
      next_dav_active = 1'b1;
    end else if (cr1.dav_pulse) begin
      next_dav_active = 1'b0;
    end else if (fifo_pop) begin
      next_dav_active = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (srst || fifo_clr) begin
      dav_active <= 1'b0;
    end else begin
      dav_active <= next_dav_active;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (srst || fifo_clr) begin
      O_SAMPLES_READY <= ~CR1_INIT.dav_polarity;
    end else begin
      O_SAMPLES_READY <= cr1.dav_polarity ? next_dav_active : ~next_dav_active;
    end
  end

  // ---------------------------------------------------------------
  // converter side outputs
  // ---------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (srst) begin
      O_CHAN_IDX <= '0;
      O_ZERO_INPUT <= 1'b0;
      O_CONV_READY <= 1'b0;
    end else begin
      O_CHAN_IDX <= (srst || fifo_clr || wr_cr0) ? '0 : next_chan_idx;
      O_ZERO_INPUT <= cal_pending & ~(conv_take & cal_pending) |
                      (wr_cr1 & wdata.offset_cal);
      O_CONV_READY <= (startup <= 3'h1) & ~fifo_clr &
                      ((fill < 5'(FIFO_DEPTH)) | fifo_pop);
    end
  end

endmodule // afc_ctrl

// ==== afc_ctrl_props.sv ====
`timescale 1ns/100ps
module afc_ctrl_props import afc_pkg::*; (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SELECT_LOW_N,
  input wire logic I_SELECT_HIGH,
  input wire logic I_RD_N,
  input wire logic I_WR_N,
  input wire logic [DATA_W-1:0] I_DATA,
  input wire logic [DATA_W-1:0] O_DATA,
  input wire logic O_DATA_OE_N,
  input wire logic I_CONV_VALID,
  input wire logic [DATA_W-1:0] I_CONV_DATA,
  input wire logic O_CONV_READY,
  input wire logic [CHAN_W-1:0] O_CHAN_IDX,
  input wire logic O_ZERO_INPUT,
  input wire logic O_SAMPLES_READY
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic sel_ok;
  logic sep_rd;
  logic rd_any_q;
  assign sel_ok = !I_SELECT_LOW_N && I_SELECT_HIGH;
  assign sep_rd = sel_ok && !I_RD_N && I_WR_N;
  always_ff @(posedge I_SYS_CLK) begin
    rd_any_q <= sel_ok && I_WR_N;
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_read_drives_bus: assert property ($rose(sep_rd) |=> !O_DATA_OE_N)
    else $error("data bus not driven after read start");
  a_drive_needs_read: assert property (!O_DATA_OE_N |-> rd_any_q)
    else $error("data bus driven without a read");
  a_release_bus: assert property (!sel_ok |=> O_DATA_OE_N)
    else $error("data bus still driven after deselect");
  a_data_holds: assert property (O_DATA_OE_N |-> $stable(O_DATA))
    else $error("read data changed outside a read");
  a_reset_values: assert property ($fell(I_SYS_RST) |-> O_DATA_OE_N && !O_SAMPLES_READY
    && O_CHAN_IDX == '0 && !O_ZERO_INPUT && !O_CONV_READY)
    else $error("outputs not at reset values");
  a_index_still: assert property ((!I_CONV_VALID && I_WR_N) [*2] |=> $stable(O_CHAN_IDX))
    else $error("channel index moved without a sample");
  a_cal_consumes: assert property (O_ZERO_INPUT && I_CONV_VALID |=> !O_ZERO_INPUT)
    else $error("calibration not ended by a conversion");
  a_cal_needs_write: assert property ($rose(O_ZERO_INPUT) |->
    !$past(I_WR_N) || !$past(I_WR_N, 2))
    else $error("calibration started without a write");

  c_read: cover property ($rose(sep_rd));
  c_cal: cover property ($rose(O_ZERO_INPUT));
  c_full: cover property (I_CONV_VALID && !O_CONV_READY);
endmodule // afc_ctrl_props

// ==== afc_host_model.sv ====
`timescale 1ns/100ps
module afc_host_model import afc_pkg::*; (
  input wire logic i_clk,
  input wire logic [DATA_W-1:0] i_data,
  output logic o_select_low_n,
  output logic o_select_high,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [DATA_W-1:0] o_data
);
  // released bus shows inverted last data
  task automatic idle();
    o_select_low_n = 1'b1;
    o_select_high = 1'b0;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_data = ~o_data;
  endtask

  initial begin
    o_data = '0;
    idle();
  end

  task automatic write_reg(input logic [1:0] sel, input logic [CR_W-1:0] val);
    @(posedge i_clk);
    #1;
    o_select_low_n = 1'b0;
    o_select_high = 1'b1;
    o_wr_n = 1'b0;
    o_data = {sel, val};
    repeat ($urandom_range(1, 2)) @(posedge i_clk);
    #1;
    idle();
  endtask

  task automatic read_word(input logic comb, input logic good_sel,
                           output logic [DATA_W-1:0] word);
    @(posedge i_clk);
    #1;
    o_select_low_n = 1'b0;
    o_select_high = good_sel;
    o_rd_n = comb;
    repeat ($urandom_range(2, 3)) @(posedge i_clk);
    word = i_data;
    #1;
    idle();
  endtask
endmodule // afc_host_model

// ==== adc_fifo_control_register_test.sv ====
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module adc_fifo_control_register_test import afc_pkg::*; ;
  logic sys_clk, sys_rst, sel_low_n, sel_high, rd_n, wr_n, oe_n, conv_valid, conv_ready;
  logic zero_input, samples_ready, ovf, cal_pend, comb;
  logic [DATA_W-1:0] host_data, rdata, bus, conv_data, offset, w;
  logic [CHAN_W-1:0] chan_idx;
  logic [DATA_W-1:0] q[$];
  int errors, tests_run, cycles, exp_idx, nch_cur, pulses, seed;
  localparam logic [CR_W-1:0] CR0_TAB [4] = '{10'h020, 10'h0A8, 10'h090, 10'h098};

  assign bus = !oe_n ? rdata : host_data;

  afc_ctrl u_dut (.I_SYS_CLK(sys_clk), .I_SYS_RST(sys_rst), .I_SELECT_LOW_N(sel_low_n),
    .I_SELECT_HIGH(sel_high), .I_RD_N(rd_n), .I_WR_N(wr_n), .I_DATA(bus), .O_DATA(rdata),
    .O_DATA_OE_N(oe_n), .I_CONV_VALID(conv_valid), .I_CONV_DATA(conv_data),
    .O_CONV_READY(conv_ready), .O_CHAN_IDX(chan_idx), .O_ZERO_INPUT(zero_input),
    .O_SAMPLES_READY(samples_ready));
  afc_host_model u_host (.i_clk(sys_clk), .i_data(bus), .o_select_low_n(sel_low_n),
    .o_select_high(sel_high), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(host_data));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic int tl_of(input int nch, input int code);
    int t[4][4] = '{'{1, 4, 8, 14}, '{2, 4, 8, 12}, '{3, 6, 9, 12}, '{4, 8, 12, 4}};
    return t[nch-1][code];
  endfunction

  task automatic stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic push(input logic [DATA_W-1:0] d);
    if (!cal_pend) `CHECK_EQ(chan_idx, CHAN_W'(exp_idx))
    @(posedge sys_clk);
    #1;
    conv_valid = 1'b1;
    conv_data = d;
    tick(1);
    conv_valid = 1'b0;
    conv_data = ~d;
    if (cal_pend) begin
      offset = d - 12'h800;
      cal_pend = 1'b0;
    end else if (q.size() < FIFO_DEPTH) begin
      q.push_back(d - offset);
      exp_idx = (exp_idx + 1) % nch_cur;
    end else ovf = 1'b1;
  endtask

  task automatic rd_fifo(input logic fmt);
    logic [DATA_W-1:0] v;
    u_host.read_word(comb, 1'b1, w);
    v = q.pop_front();
    `CHECK_EQ(w, fmt ? v : v ^ 12'h800)
  endtask

  task automatic soft_reset();
    u_host.write_reg(REG_SEL_CR1, 10'h001);
    q.delete();
    comb = 1'b0;
    offset = '0;
    cal_pend = 1'b0;
    ovf = 1'b0;
    exp_idx = 0;
    nch_cur = 1;
    tick(8);
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    conv_valid = 1'b0;
    conv_data = '0;
    {comb, ovf, cal_pend, offset, errors, tests_run, cycles, exp_idx} = '0;
    nch_cur = 1;
    seed = $urandom(32'h9639);
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    conv_valid = 1'b1;
    conv_data = 12'h101;
    for (int i = 2; i <= 6; i++) begin
      tick(1);
      conv_data = DATA_W'(12'h100 + i);
    end
    tick(1);
    conv_valid = 1'b0;
    q.push_back(12'h106);
    pulses = 0;
    repeat (6) begin
      tick(1);
      if (samples_ready === 1'b1) pulses++;
    end
    `CHECK_EQ(pulses, 1)
    rd_fifo(1'b0);
    for (int n = 1; n <= 4; n++) begin
      for (int c = 0; c < 4; c++) begin
        logic pol, fmt, cmb;
        int tl;
        pol = 1'($urandom);
        fmt = 1'($urandom);
        cmb = 1'($urandom);
        tl = tl_of(n, c);
        soft_reset();
        u_host.write_reg(REG_SEL_CR0, CR0_TAB[n-1]);
        u_host.write_reg(REG_SEL_CR1, {2'b00, fmt, cmb, pol, 1'b0, c[1:0], 2'b00});
        comb = cmb;
        nch_cur = n;
        repeat (tl - 1) push(DATA_W'($urandom));
        tick(2);
        `CHECK_EQ(samples_ready, ~pol)
        push(DATA_W'($urandom));
        tick(2);
        `CHECK_EQ(samples_ready, pol)
        u_host.read_word(comb, 1'b0, w);
        `CHECK_EQ(samples_ready, pol)
        rd_fifo(fmt);
        `CHECK_EQ(samples_ready, ~pol)
        repeat (tl - 1) rd_fifo(fmt);
      end
    end
    soft_reset();
    u_host.write_reg(REG_SEL_CR0, 10'h020);
    u_host.write_reg(REG_SEL_CR1, 10'h0B0);
    repeat (3) push(DATA_W'($urandom));
    u_host.write_reg(REG_SEL_CR1, 10'h0B2);
    q.delete();
    repeat (FIFO_DEPTH) push(DATA_W'($urandom));
    // ready is registered, one cycle behind the fill
    tick(1);
    `CHECK_EQ(conv_ready, 1'b0)
    push(DATA_W'($urandom));
    for (int k = 0; k < 2; k++) begin
      u_host.write_reg(REG_SEL_CR1, 10'h2B0);
      u_host.read_word(comb, 1'b1, w);
      `CHECK_EQ(w, {REG_SEL_CR0, 10'h020})
      u_host.read_word(comb, 1'b1, w);
      `CHECK_EQ(w, {REG_SEL_CR1, 10'h2B0 | {8'h00, ovf, 1'b0}})
      ovf = 1'b0;
    end
    repeat (FIFO_DEPTH) rd_fifo(1'b1);
    soft_reset();
    u_host.write_reg(REG_SEL_CR1, 10'h1B0);
    cal_pend = 1'b1;
    tick(1);
    `CHECK_EQ(zero_input, 1'b1)
    push(DATA_W'($urandom));
    `CHECK_EQ(zero_input, 1'b0)
    push(DATA_W'($urandom));
    rd_fifo(1'b1);
    soft_reset();
    push(DATA_W'($urandom));
    rd_fifo(1'b0);
    stop_test();
  end
endmodule // adc_fifo_control_register_test

bind afc_ctrl afc_ctrl_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
  .I_SELECT_LOW_N(I_SELECT_LOW_N), .I_SELECT_HIGH(I_SELECT_HIGH), .I_RD_N(I_RD_N),
  .I_WR_N(I_WR_N), .I_DATA(I_DATA), .O_DATA(O_DATA), .O_DATA_OE_N(O_DATA_OE_N),
  .I_CONV_VALID(I_CONV_VALID), .I_CONV_DATA(I_CONV_DATA), .O_CONV_READY(O_CONV_READY),
  .O_CHAN_IDX(O_CHAN_IDX), .O_ZERO_INPUT(O_ZERO_INPUT), .O_SAMPLES_READY(O_SAMPLES_READY));
